// *** rtl/ssc_spi_slave.sv ***
// Serial command port slave: framing, echo, read return and decode
// How it works
// - A command is exactly 32 bits: 8 opcode, 8 address, 16 data, in order.
// - The port is always slave and never drives the serial clock or select.
// - Select falling opens a frame and select rising after 32 clocks ends it.
// - The input line is sampled on each rising serial clock edge.
// - On a write the opcode, address and first data byte echo 8 clocks late.
// - Select rising before the 32nd clock aborts and the command is dropped.
// - On a read the opcode echo is followed directly by the data word.
// - Output bits are valid at rising edges, where the master takes them.
// - Read data starts on the 17th rising edge after select falls.
// - The first eight bits are the opcode, bit 7 first.
// - Register fetch decodes from opcode bits 6 to 2 only, register store from bits 6, 5, 4 and 2.
// - Memory store and wipe operations decode from the upper opcode bits, fetch from bits 6 to 3.
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_slave #(
   parameter int AW = ssc_pkg::ADDR_BITS,
   parameter int DW = ssc_pkg::DATA_BITS
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                sclk,
   input  wire logic                cs_n,
   input  wire logic                sdi,
   output logic                     sdo,
   output logic                     sdo_oe,
   output logic                     cmd_valid,
   output ssc_pkg::ssc_cmd_t        cmd_kind,
   output logic [AW-1:0]            cmd_addr,
   output logic [DW-1:0]            cmd_data,
   output logic                     rd_req,
   output ssc_pkg::ssc_cmd_t        rd_kind,
   output logic [AW-1:0]            rd_addr,
   input  wire logic [DW-1:0]       rd_data
);
   localparam int CW = ssc_pkg::CNT_W;

   logic [2:0]                       lvl;
   logic [2:0]                       rse;
   logic [2:0]                       fll;
   logic [ssc_pkg::FRAME_BITS-1:0]   shreg;
   logic [CW-1:0]                    bit_cnt;
   logic [ssc_pkg::OP_BITS-1:0]      opcode;
   logic [DW-1:0]                    dshift;
   ssc_pkg::ssc_cmd_t                kind;

   // Link pins other than sdo are only ever inputs here
   ssc_sync #(.W(3), .RST_VAL(ssc_pkg::SYNC_RST)) u_sync (
      .clk      (clk),
      .rstn     (rstn),
      .async_in ({cs_n, sclk, sdi}),
      .level    (lvl),
      .rise     (rse),
      .fall     (fll)
   );

   wire cs_n_s    = lvl[2];
   wire cs_end    = rse[2];
   wire sdi_s     = lvl[0];
   wire sclk_rise = rse[1] & ~cs_n_s;
   wire sclk_fall = fll[1] & ~cs_n_s;
   wire cnt_full  = (bit_cnt == ssc_pkg::CNT_OVER);
   wire op_done   = sclk_rise && (bit_cnt == ssc_pkg::CNT_OP - 6'h01);
   wire addr_done = sclk_rise && (bit_cnt == ssc_pkg::CNT_ADDR - 6'h01);
   wire [ssc_pkg::OP_BITS-1:0] next_opcode = {shreg[6:0], sdi_s};
   wire is_read   = (kind == ssc_pkg::CMD_REG_FETCH) ||
                    (kind == ssc_pkg::CMD_NVM_FETCH);
   wire in_data   = bit_cnt >= ssc_pkg::CNT_ADDR &&
                    bit_cnt < ssc_pkg::CNT_FRAME;
   wire echo_on   = bit_cnt >= ssc_pkg::CNT_OP &&
                    bit_cnt < ssc_pkg::CNT_FRAME;
   wire frame_ok  = cs_end && (bit_cnt == ssc_pkg::CNT_FRAME);

   // Opcode decode; register patterns first, memory patterns after
   wire dec_reg_st = opcode[6] & ~opcode[5] & opcode[4] & ~opcode[2];
   wire dec_reg_fe = opcode[6:2] == 5'h12;
   wire dec_nvm_st = opcode[7:4] == 4'h1;
   wire dec_nvm_wp = opcode[7:5] == 3'h1;
   wire dec_nvm_fe = opcode[6:3] == 4'h1;
   wire dec_nvm_bs = opcode[7:4] == 4'h9;
   wire dec_nvm_bw = opcode[7:5] == 3'h5;

   always_comb begin
      if (dec_reg_st)
         kind = ssc_pkg::CMD_REG_STORE;
      else if (dec_reg_fe)
         kind = ssc_pkg::CMD_REG_FETCH;
      else if (dec_nvm_st)
         kind = ssc_pkg::CMD_NVM_STORE;
      else if (dec_nvm_wp)
         kind = ssc_pkg::CMD_NVM_WIPE;
      else if (dec_nvm_fe)
         kind = ssc_pkg::CMD_NVM_FETCH;
      else if (dec_nvm_bs)
         kind = ssc_pkg::CMD_NVM_BSTORE;
      else if (dec_nvm_bw)
         kind = ssc_pkg::CMD_NVM_BWIPE;
      else
         kind = ssc_pkg::CMD_NONE;
   end

   // Bit counter saturates past a full frame so overlong frames fail
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt <= ssc_pkg::CNT_RST;
      end else if (cs_n_s) begin
         bit_cnt <= ssc_pkg::CNT_RST;
      end else if (sclk_rise && !cnt_full) begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end

   // Frame shifter, MSB first; opcode held once 8 bits are in
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shreg  <= '0;
         opcode <= '0;
      end else if (sclk_rise) begin
         shreg <= {shreg[ssc_pkg::FRAME_BITS-2:0], sdi_s};
         if (op_done)
            opcode <= next_opcode;
      end
   end

   // Read fetch requested once the address is complete, data due by fall
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_req  <= 1'b0;
         rd_kind <= ssc_pkg::CMD_NONE;
         rd_addr <= '0;
      end else begin
         rd_req <= addr_done && is_read;
         if (addr_done && is_read) begin
            rd_kind <= kind;
            rd_addr <= {shreg[AW-2:0], sdi_s};
         end
      end
   end

   // Output moves on falling edges so it is settled at each rise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdo    <= 1'b0;
         dshift <= '0;
      end else if (cs_n_s) begin
         sdo    <= 1'b0;
         dshift <= '0;
      end else if (sclk_fall) begin
         if (is_read && bit_cnt == ssc_pkg::CNT_ADDR) begin
            sdo    <= rd_data[DW-1];
            dshift <= {rd_data[DW-2:0], 1'b0};
         end else if (is_read && in_data) begin
            sdo    <= dshift[DW-1];
            dshift <= {dshift[DW-2:0], 1'b0};
         end else if (echo_on) begin
            sdo <= shreg[ssc_pkg::ECHO_DELAY-1];
         end
      end
   end

   assign sdo_oe = ~cs_n_s;

   // Command issued only for an exact frame with a known opcode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_valid <= 1'b0;
         cmd_kind  <= ssc_pkg::CMD_NONE;
         cmd_addr  <= '0;
         cmd_data  <= '0;
      end else begin
         cmd_valid <= frame_ok && (kind != ssc_pkg::CMD_NONE);
         if (frame_ok) begin
            cmd_kind <= kind;
            cmd_addr <= shreg[DW+AW-1:DW];
            cmd_data <= shreg[DW-1:0];
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_addr_in;
      sclk_rise && bit_cnt == ssc_pkg::CNT_ADDR - 6'h01;
   endsequence
   sequence s_fetch_opcode;
      is_read ##0 s_addr_in;
   endsequence

   a_idle_quiet: assert property (cs_n_s |-> !sdo_oe)
      else $error("output enabled while deselected");
   a_count_step: assert property (
      sclk_rise && bit_cnt < ssc_pkg::CNT_FRAME |=>
      bit_cnt == $past(bit_cnt) + 6'h01)
      else $error("bit count did not advance on rising edge");
   a_exact_frame: assert property (
      cmd_valid |-> $past(bit_cnt) == ssc_pkg::CNT_FRAME)
      else $error("command issued for a frame not 32 bits long");
   a_abort_drop: assert property (
      cs_end && bit_cnt != ssc_pkg::CNT_FRAME |=> !cmd_valid)
      else $error("aborted frame produced a command");
   a_unknown_op: assert property (
      cmd_valid |-> cmd_kind != ssc_pkg::CMD_NONE)
      else $error("unknown opcode was issued");
   a_reg_fetch_dec: assert property (
      cmd_valid && cmd_kind == ssc_pkg::CMD_REG_FETCH |->
      $past(opcode[6:2]) == 5'h12)
      else $error("register fetch decoded from wrong bits");
   a_nvm_store_dec: assert property (
      cmd_valid && cmd_kind == ssc_pkg::CMD_NVM_STORE |->
      $past(opcode[7:4]) == 4'h1)
      else $error("memory store decoded from wrong bits");
   a_read_request: assert property (s_fetch_opcode |=> rd_req)
      else $error("read fetch not requested after address");
   a_read_first: assert property (
      sclk_fall && is_read && bit_cnt == ssc_pkg::CNT_ADDR |=>
      sdo == $past(rd_data[DW-1]))
      else $error("read data did not follow opcode echo");
   a_sdo_on_fall: assert property (
      !cs_n_s && !$past(cs_n_s) && $changed(sdo) |-> $past(sclk_fall))
      else $error("output changed away from a falling edge");
   a_echo_opcode: assert property (
      sclk_fall && bit_cnt == ssc_pkg::CNT_OP |=> sdo == opcode[7])
      else $error("opcode echo not 8 clocks late");
endmodule
`default_nettype wire

// *** rtl/ssc_pkg.sv ***
// Constants and types shared by the sensor command port
package ssc_pkg;
   localparam int FRAME_BITS  = 32;
   localparam int OP_BITS     = 8;
   localparam int ADDR_BITS   = 8;
   localparam int DATA_BITS   = 16;
   localparam int ECHO_DELAY  = 8;
   localparam int READ_EDGE   = 17;
   localparam int CNT_W       = 6;
   localparam logic [CNT_W-1:0] CNT_FRAME = 6'h20;
   localparam logic [CNT_W-1:0] CNT_OP    = 6'h08;
   localparam logic [CNT_W-1:0] CNT_ADDR  = 6'h10;
   localparam logic [CNT_W-1:0] CNT_OVER  = 6'h21;
   localparam logic [CNT_W-1:0] CNT_RST   = 6'h00;
   localparam logic [2:0] SYNC_RST        = 3'h4;
   localparam int CLK_NS        = 25;
   localparam int SCLK_MIN_NS   = 8000;
   localparam int SCLK_MIN_CYC  = (SCLK_MIN_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      CMD_NONE        = 3'b000,
      CMD_REG_STORE   = 3'b001,
      CMD_REG_FETCH   = 3'b010,
      CMD_NVM_STORE   = 3'b011,
      CMD_NVM_WIPE    = 3'b100,
      CMD_NVM_FETCH   = 3'b101,
      CMD_NVM_BSTORE  = 3'b110,
      CMD_NVM_BWIPE   = 3'b111
   } ssc_cmd_t;
endpackage

// *** rtl/ssc_sync.sv ***
// Two-flop synchronisers with edge detection behind the second flop
`timescale 1ns/1ps
`default_nettype none
module ssc_sync #(
   parameter int         W       = 3,
   parameter logic [2:0] RST_VAL = ssc_pkg::SYNC_RST
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta;
   logic [W-1:0] last;

   // Only the second stage is looked at by the edge logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta  <= RST_VAL[W-1:0];
         level <= RST_VAL[W-1:0];
         last  <= RST_VAL[W-1:0];
      end else begin
         meta  <= async_in;
         level <= meta;
         last  <= level;
      end
   end

   assign rise = level & ~last;
   assign fall = ~level & last;
endmodule
`default_nettype wire

// *** tb/ssc_master_model.sv ***
// Master model that frames commands on the serial port
`timescale 1ns/1ps
`default_nettype none
module ssc_master_model #(
   parameter int HALF = 160
) (
   input  wire logic clk,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // Half period of 160 clk keeps the link at 8 us per bit
   task automatic frame(input logic [31:0] word, input int nbits,
                        output logic [31:0] seen);
      seen = '0;
      @(negedge clk);
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi = word[31-i];
         repeat (HALF) @(negedge clk);
         seen[31-i] = sdo;
         sclk = 1'b1;
         repeat (HALF) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (HALF) @(negedge clk);
      cs_n = 1'b1;
      // Released line flips so a stale bit never looks valid
      sdi  = ~sdi;
   endtask
endmodule
`default_nettype wire

// *** tb/ssc_spi_slave_tb.sv ***
// Self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_slave_tb;
   logic              clk, rstn, sclk, cs_n, sdi, sdo, sdo_oe;
   logic              cmd_valid, rd_req;
   ssc_pkg::ssc_cmd_t cmd_kind, rd_kind;
   logic [7:0]        cmd_addr, rd_addr;
   logic [15:0]       cmd_data, rd_data;
   logic [31:0]       seen;
   int                mismatches = 0;
   int                checks_done = 0;
   int                n_cmd = 0;
   int                n_rd = 0;
   int                n_oe = 0;
   int                dc, dr;
   // Opcodes in enum order; register opcodes and the plain memory wipe opcode set their spare bits to 1 to catch sloppy decode
   logic [7:0]        ops [7] = '{8'hdb, 8'hcb, 8'h17, 8'h3f, 8'h8d,
                                  8'h9a, 8'ha5};
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ssc_spi_slave i_dut (
      .clk       (clk),
      .rstn      (rstn),
      .sclk      (sclk),
      .cs_n      (cs_n),
      .sdi       (sdi),
      .sdo       (sdo),
      .sdo_oe    (sdo_oe),
      .cmd_valid (cmd_valid),
      .cmd_kind  (cmd_kind),
      .cmd_addr  (cmd_addr),
      .cmd_data  (cmd_data),
      .rd_req    (rd_req),
      .rd_kind   (rd_kind),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data)
   );
   ssc_master_model i_master (
      .clk  (clk),
      .sclk (sclk),
      .cs_n (cs_n),
      .sdi  (sdi),
      .sdo  (sdo)
   );
   // Pulses are counted so a doubled or missing one shows
   always @(posedge clk) begin
      if (sdo_oe === 1'b1)
         n_oe <= n_oe + 1;
      if (cmd_valid === 1'b1)
         n_cmd <= n_cmd + 1;
      if (rd_req === 1'b1)
         n_rd <= n_rd + 1;
   end
   task automatic compare(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic send(input logic [31:0] word, input int nbits);
      int c0;
      int r0;
      int o0;
      c0 = n_cmd;
      r0 = n_rd;
      o0 = n_oe;
      i_master.frame(word, nbits, seen);
      repeat (10) @(negedge clk);
      dc = n_cmd - c0;
      dr = n_rd - r0;
      compare("oe_in_frame", 32'h1, 32'(n_oe > o0));
      compare("idle_out", 32'h0, {30'h0, sdo_oe, sdo});
   endtask
   task automatic test_writes();
      logic [31:0] w;
      for (int i = 0; i < 7; i++) begin
         if (i == 1 || i == 4)
            continue;
         w = {ops[i], 8'ha5 ^ 8'(i), 16'h8001};
         send(w, 32);
         compare("write_echo", {8'h0, w[31:8]}, seen);
         compare("write_valid", 32'h1, 32'(dc));
         compare("write_kind", 32'(i + 1), {29'h0, cmd_kind});
         compare("write_fields", {8'h0, w[23:0]},
                 {8'h0, cmd_addr, cmd_data});
         compare("write_no_fetch", 32'h0, 32'(dr));
      end
   endtask
   task automatic test_reads();
      logic [31:0] w;
      for (int i = 1; i < 5; i += 3) begin
         @(negedge clk);
         rd_data = {8'h81, ops[i]};
         w = {ops[i], 8'h3c + 8'(i), 16'hffff};
         send(w, 32);
         compare("read_return", {8'h0, ops[i], rd_data},
                 seen);
         compare("read_fetch", 32'h1, 32'(dr));
         compare("read_target", {21'h0, 3'(i + 1), w[23:16]},
                 {21'h0, rd_kind, rd_addr});
         compare("read_valid", 32'h1, 32'(dc));
      end
   endtask
   task automatic test_abort();
      logic [31:0] w;
      w = {8'hdb, 8'h44, 16'h1234};
      send(w, 12);
      compare("abort_echo", {8'h0, w[31:28], 20'h0}, seen);
      compare("abort_drop", 32'h0, 32'(dc + dr));
   endtask
   task automatic test_unknown();
      logic [31:0] w;
      w = {8'hff, 8'h00, 16'hffff};
      send(w, 32);
      compare("unknown_echo", {8'h0, w[31:8]}, seen);
      compare("unknown_drop", 32'h0, 32'(dc + dr));
   endtask
   task automatic test_reset();
      repeat (4) @(negedge clk);
      compare("reset_out", 32'h0,
              {28'h0, cmd_valid, rd_req, sdo_oe, sdo});
   endtask
   task automatic conclude();
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      rd_data = 16'h0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      test_reset();
      test_writes();
      test_reads();
      test_abort();
      test_unknown();
      conclude();
   end
   // Eight frames of 256 us and one 12-bit aborted frame fit well inside this span
   initial begin
      #2_400_000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
